// *** rcdc_pkg.sv ***
// Purpose: Shared constants and types for the recombiner delay control.
// Assumes: Word-indexed register map; byte address is four times the index.
// Notes: Group count and link count are fixed.
package rcdc_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NGRP = 8;
  localparam int NLINK = 16;
  localparam int MEAS_W = 12;
  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [11:0] IDX_LINK_EN = 12'h201;
  localparam logic [11:0] IDX_INC = 12'h281;
  localparam logic [11:0] IDX_DEC = 12'h282;
  localparam logic [11:0] IDX_JOIN = 12'h283;
  localparam logic [11:0] IDX_GBAND = 12'h287;
  localparam logic [11:0] IDX_ENSTAT = 12'h2AD;
  localparam logic [11:0] IDX_IRQ_ST = 12'h2B0;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h2B1;
  localparam logic [11:0] IDX_LODS = 12'h2B2;
  localparam logic [11:0] IDX_MAXOP = 12'h2B3;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int DEFER_LSB = 8;
  localparam int IRQ_REJ = 8;
  localparam int IRQ_JOIN = 9;
  localparam logic [15:0] MIN_DELAY = 16'h0004;
  localparam logic [15:0] GBAND_RST = 16'h0004;
  localparam logic [15:0] MAXOP_RST = 16'h0100;
  localparam logic [15:0] ZERO16 = 16'h0000;
  typedef enum logic [1:0] {RCDC_IDLE, RCDC_PAUSE, RCDC_DROP, RCDC_WAITPOS} rcdc_state_t;
endpackage

// *** rcdc_grp_if.sv ***
// Purpose: Carries one group's command and status between top and controller.
// Assumes: Single clock domain.
// Notes: One instance per group.
`timescale 1ns/100ps
`default_nettype none
interface rcdc_grp_if;
  logic start_inc;
  logic start_dec;
  logic defer;
  logic [15:0] delta;
  logic cell_tick;
  logic all_ok;
  logic busy_inc;
  logic busy_dec;
  logic suspend;
  logic drop;
  logic done;
  modport ctl (input start_inc, input start_dec, input defer, input delta, input cell_tick,
    input all_ok, output busy_inc, output busy_dec, output suspend, output drop, output done);
  modport top (output start_inc, output start_dec, output defer, output delta,
    output cell_tick, output all_ok, input busy_inc, input busy_dec, input suspend,
    input drop, input done);
endinterface
`default_nettype wire

// *** rcdc_grp_ctl.sv ***
// Purpose: Per-group delay increase and decrease sequencer.
// Assumes: cell_tick pulses once per cell time.
// Notes: Drop pulses are one cell each.
`timescale 1ns/100ps
`default_nettype none
module rcdc_grp_ctl
(
  input wire logic clock,
  input wire logic sys_rst,
  rcdc_grp_if.ctl g
);
  rcdc_pkg::rcdc_state_t state_ff, nxt_state;
  logic [15:0] cnt_ff, nxt_cnt;
  logic drop_ff, nxt_drop;
  logic done_ff, nxt_done;
  logic susp_ff, nxt_susp;
  logic step;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_drop = 1'b0;
    nxt_done = 1'b0;
    step = !g.defer || g.cell_tick;
    unique case (state_ff)
      rcdc_pkg::RCDC_IDLE:
      begin
        if (g.start_inc && g.delta != rcdc_pkg::ZERO16)
        begin
          nxt_state = rcdc_pkg::RCDC_PAUSE;
          nxt_cnt = g.delta;
        end
        else if (g.start_dec && g.delta != rcdc_pkg::ZERO16)
        begin
          nxt_state = rcdc_pkg::RCDC_DROP;
          nxt_cnt = g.delta;
        end
        else if (g.start_inc || g.start_dec)
          nxt_done = 1'b1;
      end
      rcdc_pkg::RCDC_PAUSE:
        if (g.cell_tick)
        begin
          nxt_cnt = cnt_ff - 16'h0001;
          if (cnt_ff == 16'h0001)
          begin
            nxt_state = rcdc_pkg::RCDC_IDLE;
            nxt_done = 1'b1;
          end
        end
      rcdc_pkg::RCDC_DROP:
        // drop removed cells; immediate or per cell time
        if (step)
        begin
          nxt_drop = 1'b1;
          nxt_cnt = cnt_ff - 16'h0001;
          if (cnt_ff == 16'h0001)
            nxt_state = rcdc_pkg::RCDC_WAITPOS;
        end
      rcdc_pkg::RCDC_WAITPOS:
        // hold until all joined links of the group reach four
        if (g.all_ok)
        begin
          nxt_state = rcdc_pkg::RCDC_IDLE;
          nxt_done = 1'b1;
        end
    endcase
    nxt_susp = nxt_state == rcdc_pkg::RCDC_PAUSE || nxt_state == rcdc_pkg::RCDC_WAITPOS
      || !g.all_ok;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_ff <= rcdc_pkg::RCDC_IDLE;
      cnt_ff <= rcdc_pkg::ZERO16;
      drop_ff <= 1'b0;
      done_ff <= 1'b0;
      susp_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      drop_ff <= nxt_drop;
      done_ff <= nxt_done;
      susp_ff <= nxt_susp;
    end
  end

  assign g.busy_inc = state_ff == rcdc_pkg::RCDC_PAUSE;
  assign g.busy_dec = state_ff == rcdc_pkg::RCDC_DROP || state_ff == rcdc_pkg::RCDC_WAITPOS;
  assign g.suspend = susp_ff;
  assign g.drop = drop_ff;
  assign g.done = done_ff;

  AST_PAUSE_SUSPENDS: assert property (@(posedge clock) disable iff (sys_rst)
    state_ff == rcdc_pkg::RCDC_PAUSE |-> susp_ff)
    else $error("Recombiner not suspended during pause.");
  AST_PAUSE_NO_DROP: assert property (@(posedge clock) disable iff (sys_rst)
    state_ff == rcdc_pkg::RCDC_PAUSE |=> !drop_ff)
    else $error("Cell dropped during increase.");
  AST_DEFER_ON_TICK: assert property (@(posedge clock) disable iff (sys_rst)
    state_ff == rcdc_pkg::RCDC_DROP && g.defer && !g.cell_tick |=> !drop_ff)
    else $error("Deferred drop outside a cell time.");
  AST_WAIT_HOLDS: assert property (@(posedge clock) disable iff (sys_rst)
    state_ff == rcdc_pkg::RCDC_WAITPOS && !g.all_ok |=> state_ff == rcdc_pkg::RCDC_WAITPOS)
    else $error("Left wait before delays recovered.");
  AST_DONE_IDLE: assert property (@(posedge clock) disable iff (sys_rst)
    done_ff |-> state_ff == rcdc_pkg::RCDC_IDLE)
    else $error("Done raised while busy.");
endmodule
`default_nettype wire

// *** rcdc_top.sv ***
// Purpose: Receive recombiner delay control with a classic Wishbone slave.
// Assumes: Cell-side inputs come from logic on the same clock.
// Notes: Acknowledge is registered, one cycle after the strobe.
//
// What this block does
// - Increase pauses the recombiner for that many cell times, no cell lost.
// - Command bit returns to zero when the adjustment finishes.
// - Decrease drops the cells matching the removed delay.
// - Decrease is immediate or deferred, as software selects.
// - Decrease takes its cell count from the same per-group register.
// - After a decrease, suspend until every joined link delay of the group reaches four.
// - New link delay is measured and checked against operating limits.
// - Enable state bit sets only once the link really joins.
// - Optional join on the first user cell, per link.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module rcdc_top
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic cell_tick,
  input wire logic [15:0] link_user_cell,
  input wire logic meas_valid,
  input wire logic [3:0] meas_link,
  input wire logic [11:0] meas_delay,
  output logic [7:0] grp_suspend,
  output logic [7:0] grp_drop,
  output logic [15:0] link_joined
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d,
    input logic [3:0] sel);
    wmerge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [15:0] w1c(input logic [15:0] st, input logic [31:0] d,
    input logic [3:0] sel);
    w1c = st & ~{sel[1] ? d[15:8] : 8'h00, sel[0] ? d[7:0] : 8'h00};
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] en_ff [rcdc_pkg::NGRP];
  logic [15:0] nxt_en [rcdc_pkg::NGRP];
  logic [15:0] gb_ff [rcdc_pkg::NGRP];
  logic [15:0] nxt_gb [rcdc_pkg::NGRP];
  logic [7:0] defer_ff, nxt_defer;
  logic [15:0] autojoin_ff, nxt_autojoin;
  logic [15:0] maxop_ff, nxt_maxop;
  logic [15:0] mask_ff, nxt_mask;
  logic [15:0] stat_ff, nxt_stat;
  logic [15:0] joined_ff, nxt_joined;
  logic [15:0] seen_ff, nxt_seen;
  logic [15:0] dok_ff, nxt_dok;
  logic [15:0] lods_ff, nxt_lods;
  logic [31:0] rdat_ff, nxt_rdat;
  logic ack_ff, nxt_ack;
  logic irq_ff, nxt_irq;
  logic [7:0] susp_ff, nxt_susp;
  logic [7:0] drop_ff, nxt_drop;
  logic [7:0] start_inc, start_dec;
  logic [7:0] busy_inc, busy_dec, g_susp, g_drop, g_done;
  logic [7:0] all_ok;
  logic [15:0] member;
  logic [11:0] idx;
  logic req, wr, rd;
  logic meas_neg, meas_low, meas_high;

  assign idx = wb_adr_i[13:2];
  assign req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
  assign rd = req && !wb_we_i;

  // ----------------------------------------
  // Group controllers
  // ----------------------------------------
  rcdc_grp_if gif [rcdc_pkg::NGRP] ();

  for (genvar gi = 0; gi < rcdc_pkg::NGRP; gi++)
  begin : g_grp
    assign gif[gi].start_inc = start_inc[gi];
    assign gif[gi].start_dec = start_dec[gi];
    assign gif[gi].defer = defer_ff[gi];
    assign gif[gi].delta = gb_ff[gi];
    assign gif[gi].cell_tick = cell_tick;
    // every joined link of the group at least four
    assign gif[gi].all_ok = &(dok_ff | ~(joined_ff & en_ff[gi]));
    assign all_ok[gi] = gif[gi].all_ok;
    assign busy_inc[gi] = gif[gi].busy_inc;
    assign busy_dec[gi] = gif[gi].busy_dec;
    assign g_susp[gi] = gif[gi].suspend;
    assign g_drop[gi] = gif[gi].drop;
    assign g_done[gi] = gif[gi].done;
    rcdc_grp_ctl u_ctl
    (
      .clock(clock),
      .sys_rst(sys_rst),
      .g(gif[gi])
    );
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  always_comb
  begin
    start_inc = 8'h00;
    start_dec = 8'h00;
    // only the written group bit starts
    if (wr && wb_sel_i[0] && idx == rcdc_pkg::IDX_INC)
      start_inc = wb_dat_i[7:0] & ~(busy_inc | busy_dec);
    if (wr && wb_sel_i[0] && idx == rcdc_pkg::IDX_DEC)
      start_dec = wb_dat_i[7:0] & ~(busy_inc | busy_dec);
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_comb
  begin
    for (int i = 0; i < rcdc_pkg::NGRP; i++)
    begin
      nxt_en[i] = en_ff[i];
      nxt_gb[i] = gb_ff[i];
      if (wr && idx == rcdc_pkg::IDX_LINK_EN + 12'(i))
        nxt_en[i] = wmerge(en_ff[i], wb_dat_i, wb_sel_i);
      if (wr && idx == rcdc_pkg::IDX_GBAND + 12'(i))
        nxt_gb[i] = wmerge(gb_ff[i], wb_dat_i, wb_sel_i);
    end
    nxt_defer = defer_ff;
    if (wr && wb_sel_i[1] && idx == rcdc_pkg::IDX_DEC)
      nxt_defer = wb_dat_i[15:8];
    nxt_autojoin = autojoin_ff;
    if (wr && idx == rcdc_pkg::IDX_JOIN)
      nxt_autojoin = wmerge(autojoin_ff, wb_dat_i, wb_sel_i);
    nxt_maxop = maxop_ff;
    if (wr && idx == rcdc_pkg::IDX_MAXOP)
      nxt_maxop = wmerge(maxop_ff, wb_dat_i, wb_sel_i);
    nxt_mask = mask_ff;
    if (wr && idx == rcdc_pkg::IDX_IRQ_MASK)
      nxt_mask = wmerge(mask_ff, wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < rcdc_pkg::NGRP; i++)
      begin
        en_ff[i] <= rcdc_pkg::ZERO16;
        gb_ff[i] <= rcdc_pkg::GBAND_RST;
      end
      defer_ff <= 8'h00;
      autojoin_ff <= rcdc_pkg::ZERO16;
      maxop_ff <= rcdc_pkg::MAXOP_RST;
      mask_ff <= rcdc_pkg::ZERO16;
    end
    else
    begin
      en_ff <= nxt_en;
      gb_ff <= nxt_gb;
      defer_ff <= nxt_defer;
      autojoin_ff <= nxt_autojoin;
      maxop_ff <= nxt_maxop;
      mask_ff <= nxt_mask;
    end
  end

  // ----------------------------------------
  // Link join and delay checks
  // ----------------------------------------
  assign meas_neg = meas_delay[11];
  assign meas_low = meas_neg || {4'h0, meas_delay} < rcdc_pkg::MIN_DELAY;
  assign meas_high = !meas_neg && {4'h0, meas_delay} > maxop_ff;

  always_comb
  begin
    member = 16'h0000;
    for (int i = 0; i < rcdc_pkg::NGRP; i++)
      member = member | en_ff[i];
    nxt_dok = dok_ff;
    nxt_lods = lods_ff & member;
    // check new link delay against limits
    if (meas_valid)
    begin
      nxt_dok[meas_link] = !meas_low;
      if (member[meas_link] && !joined_ff[meas_link])
        nxt_lods[meas_link] = meas_neg || meas_high;
    end
    nxt_seen = (seen_ff | link_user_cell) & member;
    nxt_joined = joined_ff & member;
    for (int l = 0; l < rcdc_pkg::NLINK; l++)
      // join only when really taken in
      if (member[l] && cell_tick && dok_ff[l] && !lods_ff[l]
          && (!autojoin_ff[l] || seen_ff[l]))
        nxt_joined[l] = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      joined_ff <= rcdc_pkg::ZERO16;
      seen_ff <= rcdc_pkg::ZERO16;
      dok_ff <= rcdc_pkg::ZERO16;
      lods_ff <= rcdc_pkg::ZERO16;
    end
    else
    begin
      joined_ff <= nxt_joined;
      seen_ff <= nxt_seen;
      dok_ff <= nxt_dok;
      lods_ff <= nxt_lods;
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  always_comb
  begin
    nxt_stat = stat_ff;
    if (wr && idx == rcdc_pkg::IDX_IRQ_ST)
      nxt_stat = w1c(stat_ff, wb_dat_i, wb_sel_i);
    // A new event wins over a clear in the same cycle.
    nxt_stat[7:0] = nxt_stat[7:0] | g_done;
    nxt_stat[rcdc_pkg::IRQ_REJ] = nxt_stat[rcdc_pkg::IRQ_REJ] | (|(nxt_lods & ~lods_ff));
    nxt_stat[rcdc_pkg::IRQ_JOIN] = nxt_stat[rcdc_pkg::IRQ_JOIN]
      | (|(nxt_joined & ~joined_ff));
    nxt_irq = |(nxt_stat & nxt_mask);
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      stat_ff <= rcdc_pkg::ZERO16;
      irq_ff <= 1'b0;
    end
    else
    begin
      stat_ff <= nxt_stat;
      irq_ff <= nxt_irq;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb
  begin
    nxt_ack = req;
    nxt_rdat = 32'h00000000;
    if (rd)
    begin
      for (int i = 0; i < rcdc_pkg::NGRP; i++)
      begin
        if (idx == rcdc_pkg::IDX_LINK_EN + 12'(i))
          nxt_rdat[15:0] = en_ff[i];
        if (idx == rcdc_pkg::IDX_GBAND + 12'(i))
          nxt_rdat[15:0] = gb_ff[i];
      end
      unique case (idx)
        // busy bits poll back to zero
        rcdc_pkg::IDX_INC: nxt_rdat[7:0] = busy_inc;
        rcdc_pkg::IDX_DEC: nxt_rdat[15:0] = {defer_ff, busy_dec};
        rcdc_pkg::IDX_JOIN: nxt_rdat[15:0] = autojoin_ff;
        rcdc_pkg::IDX_ENSTAT: nxt_rdat[15:0] = joined_ff;
        rcdc_pkg::IDX_IRQ_ST: nxt_rdat[15:0] = stat_ff;
        rcdc_pkg::IDX_IRQ_MASK: nxt_rdat[15:0] = mask_ff;
        rcdc_pkg::IDX_LODS: nxt_rdat[15:0] = lods_ff;
        rcdc_pkg::IDX_MAXOP: nxt_rdat[15:0] = maxop_ff;
        default: nxt_rdat[31:16] = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_comb
  begin
    nxt_susp = g_susp;
    nxt_drop = g_drop;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
      susp_ff <= 8'h00;
      drop_ff <= 8'h00;
    end
    else
    begin
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
      susp_ff <= nxt_susp;
      drop_ff <= nxt_drop;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign irq = irq_ff;
  assign grp_suspend = susp_ff;
  assign grp_drop = drop_ff;
  assign link_joined = joined_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_ACK_ONE: assert property (@(posedge clock) disable iff (sys_rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held two cycles.");
  AST_JOIN_NEEDS_EN: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(link_joined[3]) |-> $past(member[3]) && $past(dok_ff[3]) && $past(cell_tick))
    else $error("Link joined without enable, delay or cell time.");
  AST_AUTOJOIN: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(link_joined[6]) && $past(autojoin_ff[6]) |-> $past(seen_ff[6]))
    else $error("Auto join before first user cell.");
  AST_INC_ISOLATED: assert property (@(posedge clock) disable iff (sys_rst)
    (busy_inc & ~$past(busy_inc) & ~$past(start_inc)) == 8'h00)
    else $error("Increase spread to another group.");
  AST_LOW_SUSPENDS: assert property (@(posedge clock) disable iff (sys_rst)
    (~$past(all_ok) & ~g_susp) == 8'h00)
    else $error("Group kept running with a link below four.");
  AST_LODS_REJECT: assert property (@(posedge clock) disable iff (sys_rst)
    meas_valid && meas_neg && member[meas_link] && !joined_ff[meas_link]
    |=> lods_ff[$past(meas_link)])
    else $error("Negative delay not flagged.");
  AST_IRQ_LEVEL: assert property (@(posedge clock) disable iff (sys_rst)
    |(stat_ff & mask_ff) |-> irq)
    else $error("Interrupt missing for unmasked status.");
endmodule
`default_nettype wire

// *** rcdc_top_tb.sv ***
// Purpose: Self-checking bench for the recombiner delay control block.
// Assumes: Registers are one word each, reached over classic Wishbone.
// Notes: Cell ticks, measurements and user cells are driven by hand.
`timescale 1ns/100ps
`default_nettype none
module rcdc_top_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [13:0] wb_adr_i = 14'h0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq;
  logic cell_tick = 1'b0;
  logic [15:0] link_user_cell = 16'h0000;
  logic meas_valid = 1'b0;
  logic [3:0] meas_link = 4'h0;
  logic [11:0] meas_delay = 12'h000;
  logic [7:0] grp_suspend;
  logic [7:0] grp_drop;
  logic [15:0] link_joined;
  int n_errors = 0;
  int cmp_count = 0;
  int drop_cnt [8] = '{default: 0};
  int base;

  rcdc_top dut
  (
    .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .cell_tick(cell_tick),
    .link_user_cell(link_user_cell), .meas_valid(meas_valid), .meas_link(meas_link),
    .meas_delay(meas_delay), .grp_suspend(grp_suspend), .grp_drop(grp_drop),
    .link_joined(link_joined)
  );

  always #20 clock = ~clock;

  // Drop pulses are counted here so that none is missed while a bus cycle runs.
  always @(posedge clock)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (grp_drop[i] === 1'b1)
      begin
        drop_cnt[i] <= drop_cnt[i] + 1;
      end
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [11:0] idx, input logic [15:0] wd,
    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, wd};
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      chk("bus ack", 32'h00000001, 32'h00000000);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [15:0] wd);
    logic [31:0] rd;
    wb(1'b1, idx, wd, rd);
  endtask

  task automatic rdc(input string nm, input logic [11:0] idx, input logic [31:0] msk,
    input logic [31:0] exp);
    logic [31:0] rd;
    wb(1'b0, idx, 16'h0000, rd);
    chk(nm, exp, rd & msk);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic tick();
    @(posedge clock);
    cell_tick <= 1'b1;
    @(posedge clock);
    cell_tick <= 1'b0;
  endtask

  task automatic meas(input logic [3:0] l, input logic [11:0] d);
    @(posedge clock);
    meas_valid <= 1'b1;
    meas_link <= l;
    meas_delay <= d;
    @(posedge clock);
    meas_valid <= 1'b0;
  endtask

  function automatic int drops_all();
    int s;
    s = 0;
    foreach (drop_cnt[i]) s += drop_cnt[i];
    return s;
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rdc("guardband g0", rcdc_pkg::IDX_GBAND, 32'hFFFFFFFF, 32'h00000004);
    rdc("guardband g7", rcdc_pkg::IDX_GBAND + 12'h007, 32'hFFFFFFFF, 32'h00000004);
    rdc("max delay", rcdc_pkg::IDX_MAXOP, 32'hFFFFFFFF, 32'h00000100);
    rdc("inc reset", rcdc_pkg::IDX_INC, 32'hFFFFFFFF, 32'h00000000);
    wr(12'h300, 16'hFFFF);
    rdc("unmapped", 12'h300, 32'hFFFFFFFF, 32'h00000000);
    wr(rcdc_pkg::IDX_ENSTAT, 16'hFFFF);
    rdc("state read only", rcdc_pkg::IDX_ENSTAT, 32'hFFFFFFFF, 32'h00000000);
    $display("test regs done");
  endtask

  task automatic t_inc();
    base = drops_all();
    wr(rcdc_pkg::IDX_GBAND + 12'h003, 16'h0004);
    wr(rcdc_pkg::IDX_IRQ_MASK, 16'h0008);
    wr(rcdc_pkg::IDX_INC, 16'h0008);
    rdc("inc busy", rcdc_pkg::IDX_INC, 32'h000000FF, 32'h00000008);
    idle(2);
    chk("suspend g3", 32'h00000008, {24'h000000, grp_suspend});
    tick();
    idle(2);
    chk("suspend after 1", 32'h00000008, {24'h000000, grp_suspend});
    repeat (3) tick();
    idle(3);
    chk("suspend end", 32'h00000000, {24'h000000, grp_suspend});
    chk("no drop", base, drops_all());
    rdc("inc clear", rcdc_pkg::IDX_INC, 32'h000000FF, 32'h00000000);
    rdc("done status", rcdc_pkg::IDX_IRQ_ST, 32'hFFFFFFFF, 32'h00000008);
    chk("irq up", 32'h00000001, {31'h00000000, irq});
    wr(rcdc_pkg::IDX_IRQ_ST, 16'h0008);
    idle(2);
    chk("irq down", 32'h00000000, {31'h00000000, irq});
    $display("test increase done");
  endtask

  task automatic t_dec_now();
    base = drop_cnt[1];
    wr(rcdc_pkg::IDX_GBAND + 12'h001, 16'h0004);
    wr(rcdc_pkg::IDX_DEC, 16'h0002);
    idle(10);
    chk("drops g1", 32'(base + 4), 32'(drop_cnt[1]));
    chk("drops total", 32'(drop_cnt[1] - base), 32'(drops_all() - base));
    rdc("dec clear", rcdc_pkg::IDX_DEC, 32'h000000FF, 32'h00000000);
    chk("irq masked", 32'h00000000, {31'h00000000, irq});
    rdc("status g1", rcdc_pkg::IDX_IRQ_ST, 32'hFFFFFFFF, 32'h00000002);
    wr(rcdc_pkg::IDX_IRQ_ST, 16'h0002);
    $display("test decrease now done");
  endtask

  task automatic t_dec_defer();
    base = drop_cnt[2];
    wr(rcdc_pkg::IDX_GBAND + 12'h002, 16'h0004);
    wr(rcdc_pkg::IDX_DEC, 16'h0404);
    idle(6);
    chk("defer hold", 32'(base), 32'(drop_cnt[2]));
    tick();
    idle(3);
    chk("defer one", 32'(base + 1), 32'(drop_cnt[2]));
    // A second command while busy must be ignored.
    wr(rcdc_pkg::IDX_DEC, 16'h0404);
    repeat (3) tick();
    idle(3);
    chk("defer rest", 32'(base + 4), 32'(drop_cnt[2]));
    rdc("defer clear", rcdc_pkg::IDX_DEC, 32'h00000004, 32'h00000000);
    $display("test decrease deferred done");
  endtask

  task automatic t_join();
    meas(4'h3, 12'h005);
    wr(rcdc_pkg::IDX_LINK_EN, 16'h0008);
    idle(2);
    chk("join wait", 32'h00000000, {31'h00000000, link_joined[3]});
    tick();
    idle(2);
    chk("joined", 32'h00000008, {16'h0000, link_joined});
    rdc("state bit", rcdc_pkg::IDX_ENSTAT, 32'hFFFFFFFF, 32'h00000008);
    meas(4'h3, 12'h002);
    idle(3);
    chk("low suspend", 32'h00000001, {31'h00000000, grp_suspend[0]});
    meas(4'h3, 12'h004);
    idle(3);
    chk("low resume", 32'h00000000, {31'h00000000, grp_suspend[0]});
    wr(rcdc_pkg::IDX_LINK_EN, 16'h0038);
    meas(4'h5, 12'hFFE);
    meas(4'h4, 12'h200);
    tick();
    idle(2);
    chk("reject", 32'h00000008, {16'h0000, link_joined});
    rdc("reject flag", rcdc_pkg::IDX_LODS, 32'h00000030, 32'h00000030);
    rdc("event status", rcdc_pkg::IDX_IRQ_ST, 32'h00000300, 32'h00000300);
    meas(4'h6, 12'h006);
    wr(rcdc_pkg::IDX_JOIN, 16'h0040);
    wr(rcdc_pkg::IDX_LINK_EN, 16'h0068);
    tick();
    idle(2);
    chk("auto wait", 32'h00000000, {31'h00000000, link_joined[6]});
    @(posedge clock);
    link_user_cell <= 16'h0040;
    @(posedge clock);
    link_user_cell <= 16'h0000;
    tick();
    idle(2);
    chk("auto joined", 32'h00000001, {31'h00000000, link_joined[6]});
    wr(rcdc_pkg::IDX_LINK_EN, 16'h0040);
    idle(3);
    chk("removed", 32'h00000000, {31'h00000000, link_joined[3]});
    rdc("state clear", rcdc_pkg::IDX_ENSTAT, 32'h00000008, 32'h00000000);
    $display("test join done");
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The span covers all scenarios with a wide margin.
  initial
  begin
    #(40 * 20000);
    n_errors++;
    wrap_up();
  end

  initial
  begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs();
    t_inc();
    t_dec_now();
    t_dec_defer();
    t_join();
    wrap_up();
  end
endmodule
`default_nettype wire
